// ===== hw/clkmon_params.svh
// How it works
// - stable flag sets after two in-tolerance error samples with oscillator toggling
// - leaving off with select X1 waits for stable flag before switching modes
// - entering the off state clears the stable flag
// - self-clocked entry from off or bypassed waits for stable before oscillator watch
// - upper filter writable only in select 00, loading the whole 12-bit value
// - upper filter write ignored while an earlier latch sequence is still running
// - reference ok is high when a watched reference meets minimum frequency, and forced high with reference select 0 in bypassed or in self-clocked select 10
// - loss flag sets when a watched reference or oscillator falls below minimum
// - loss flag holds until status read then flag write, or any reset
// - engaged external drops to self-clocked on reference loss, bypassed on oscillator loss
// - bypassed external drops to self-clocked on reference loss
// - every loss fallback rewrites both select and state fields
// - engaged external loss with reference ok still set gives state 10, bypassed
// - loss in either engaged mode also raises the loss of lock flag
// - lock loss reset enabled without clock loss reset overrides the interrupt flag for a loss in either engaged mode
// - off state watches no oscillator, reference only for select 10 during restart
// - self-clocked watches oscillator; reference per select and reference select
// - internal engaged watches oscillator, reference on 11; bypassed and engaged per table
`ifndef CLKMON_PARAMS_SVH
`define CLKMON_PARAMS_SVH

`define ADR_CTRL 8'h00
`define ADR_STAT1 8'h04
`define ADR_STAT2 8'h08
`define ADR_FLTU 8'h0c
`define ADR_FLTL 8'h10
`define ADR_EVT 8'h14
`define ADR_MASK 8'h18

`define CTRL_RESET 7'h00
`define FLT_RESET 12'h800
`define STAT1_IRQ_BIT 5
`define UNLOCK_TOL 12'h004
`define LATCH_CYCLES 2'h2
`define CLK_PERIOD_NS 25
`define REF_LOSS_NS 3200
`define DCO_LOSS_NS 800
`define REF_LOSS_CYC ((`REF_LOSS_NS) / (`CLK_PERIOD_NS))
`define DCO_LOSS_CYC ((`DCO_LOSS_NS) / (`CLK_PERIOD_NS))

`endif

// ===== hw/clkmon_pkg.sv
`default_nettype none
package clkmon_pkg;

    typedef enum logic [4:0] {
        M_OFF = 5'b00001,
        M_SCM = 5'b00010,
        M_FEI = 5'b00100,
        M_FBE = 5'b01000,
        M_FEE = 5'b10000
    } mode_t;

    typedef struct packed {
        logic ref_mon;
        logic dco_mon;
        logic ok_lo;
        logic ok_hi;
    } mon_t;

    typedef struct packed {
        logic prev;
        logic [7:0] cnt;
    } watch_t;

    typedef struct packed {
        mode_t mode;
        logic [1:0] clk_sel;
        logic ref_sel;
        logic loc_dis;
        logic clock_loss_reset_en;
        logic lock_loss_reset_en;
        logic off_req;
        logic loss_of_clock_flag;
        logic loss_of_lock_flag;
        logic clockgen_irq_flag;
        logic armed;
        logic [1:0] stab_cnt;
        logic [11:0] prev_err;
        logic stable;
        logic dco_armed;
        logic [11:0] filt;
        logic [7:0] flt_low;
        logic [1:0] latch_cnt;
        logic [2:0] evt;
        logic [2:0] mask;
        logic [31:0] prdata;
        logic loc_rst;
        logic lol_rst;
    } state_t;

endpackage
`default_nettype wire

// ===== hw/freq_watch.sv
`default_nettype none
module freq_watch import clkmon_pkg::*; #(
    parameter logic [7:0] LIMIT = 8'h20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic clk_sample,
    output logic lost,
    output logic toggling
);
    watch_t s_q, s_d;

    // cycles since last edge of the sampled clock; saturates at the limit
    always_comb begin
        s_d = s_q;
        s_d.prev = clk_sample;
        if (!enable || clk_sample != s_q.prev) begin
            s_d.cnt = 8'h00;
        end else if (s_q.cnt != LIMIT) begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign lost = enable && (s_q.cnt == LIMIT);
    assign toggling = (s_q.cnt != LIMIT);
endmodule // freq_watch
`default_nettype wire

// ===== hw/clock_gen_loss_monitor.sv
// Decided for this implementation: the address map and register access over APB.
`default_nettype none
`include "clkmon_params.svh"
module clock_gen_loss_monitor import clkmon_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_clk_in,
    input wire logic loop_osc_clock,
    input wire logic [11:0] count_error,
    input wire logic sample_tick,
    input wire logic xtal_wait,
    output logic [11:0] filter_value,
    output logic [1:0] clock_state,
    output logic osc_stable_flag,
    output logic reference_ok,
    output logic clock_loss_reset,
    output logic lock_loss_reset,
    output logic irq
);
    state_t s_q, s_d;
    logic ref_lost, dco_lost, dco_toggling, ref_toggling;
    logic ref_loss, dco_loss, any_loss;
    mon_t mon;
    logic acc, wr, rd, setup, mapped;
    logic [11:0] err_diff;

    function automatic mon_t mon_cfg(mode_t m, logic [1:0] sel, logic rsel,
                                     logic armed, logic wait_x, logic dis);
        mon_t r;
        r = '0;
        case (m)
            M_OFF: begin
                r.ref_mon = (sel == 2'h2) && rsel && wait_x;
                r.ok_lo = !r.ref_mon;
            end
            M_SCM: begin
                r.dco_mon = armed;
                r.ref_mon = (sel == 2'h3) || ((sel == 2'h2) && rsel);
                r.ok_lo = !sel[1];
                r.ok_hi = (sel == 2'h2) && !rsel;
            end
            M_FEI: begin
                r.dco_mon = 1'b1;
                r.ref_mon = (sel == 2'h3);
                r.ok_lo = !r.ref_mon;
            end
            M_FBE: begin
                r.ref_mon = rsel;
                r.ok_hi = !rsel;
            end
            M_FEE: begin
                r.ref_mon = 1'b1;
                r.dco_mon = 1'b1;
            end
            default: r = '0;
        endcase
        if (dis) begin
            r.ref_mon = 1'b0;
            r.dco_mon = 1'b0;
        end
        return r;
    endfunction

    function automatic mode_t sel_mode(logic [1:0] sel);
        mode_t r;
        case (sel)
            2'h0: r = M_SCM;
            2'h1: r = M_FEI;
            2'h2: r = M_FBE;
            default: r = M_FEE;
        endcase
        return r;
    endfunction

    function automatic logic [1:0] mode_code(mode_t m);
        logic [1:0] r;
        case (m)
            M_FEI: r = 2'h1;
            M_FBE: r = 2'h2;
            M_FEE: r = 2'h3;
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    freq_watch #(.LIMIT(8'(`REF_LOSS_CYC))) u_ref_watch (
        .pclk(pclk),
        .presetn(presetn),
        .enable(1'b1),
        .clk_sample(ref_clk_in),
        .lost(ref_lost),
        .toggling(ref_toggling)
    );

    freq_watch #(.LIMIT(8'(`DCO_LOSS_CYC))) u_dco_watch (
        .pclk(pclk),
        .presetn(presetn),
        .enable(1'b1),
        .clk_sample(loop_osc_clock),
        .lost(dco_lost),
        .toggling(dco_toggling)
    );

    assign mon = mon_cfg(s_q.mode, s_q.clk_sel, s_q.ref_sel, s_q.dco_armed, xtal_wait,
                         s_q.loc_dis);
    assign ref_loss = mon.ref_mon && ref_lost;
    assign dco_loss = mon.dco_mon && dco_lost;
    assign any_loss = (ref_loss || dco_loss) && !s_q.loc_dis;
    assign reference_ok = mon.ok_hi || (!mon.ok_lo && mon.ref_mon && ref_toggling);

    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign mapped = (paddr == `ADR_CTRL) || (paddr == `ADR_STAT1) ||
                    (paddr == `ADR_STAT2) || (paddr == `ADR_FLTU) ||
                    (paddr == `ADR_FLTL) || (paddr == `ADR_EVT) || (paddr == `ADR_MASK);
    assign err_diff = (count_error >= s_q.prev_err) ? count_error - s_q.prev_err
                                                    : s_q.prev_err - count_error;

    always_comb begin
        s_d = s_q;
        s_d.loc_rst = 1'b0;
        s_d.lol_rst = 1'b0;
        if (s_q.latch_cnt != 2'h0) begin
            s_d.latch_cnt = s_q.latch_cnt - 2'h1;
        end
        // stability of the oscillator
        if (sample_tick) begin
            s_d.prev_err = count_error;
            if (err_diff <= `UNLOCK_TOL && s_q.stab_cnt != 2'h2) begin
                s_d.stab_cnt = s_q.stab_cnt + 2'h1;
            end else if (err_diff > `UNLOCK_TOL) begin
                s_d.stab_cnt = 2'h0;
            end
        end
        s_d.stable = (s_d.stab_cnt == 2'h2) && dco_toggling;
        if (s_q.stable) begin
            s_d.dco_armed = 1'b1;
        end
        // register writes
        if (wr) begin
            if (paddr == `ADR_CTRL) begin
                s_d.clk_sel = pwdata[1:0];
                s_d.ref_sel = pwdata[2];
                s_d.loc_dis = pwdata[3];
                s_d.clock_loss_reset_en = pwdata[4];
                s_d.lock_loss_reset_en = pwdata[5];
                s_d.off_req = pwdata[6];
            end else if (paddr == `ADR_STAT1) begin
                if (pwdata[`STAT1_IRQ_BIT] && s_q.armed) begin
                    s_d.loss_of_clock_flag = 1'b0;
                    s_d.loss_of_lock_flag = 1'b0;
                    s_d.clockgen_irq_flag = 1'b0;
                end
                s_d.armed = 1'b0;
            end else if (paddr == `ADR_FLTU) begin
                if (s_q.clk_sel == 2'h0 && s_q.latch_cnt == 2'h0) begin
                    s_d.filt = {pwdata[3:0], s_q.flt_low};
                    s_d.latch_cnt = `LATCH_CYCLES;
                end
            end else if (paddr == `ADR_FLTL) begin
                s_d.flt_low = pwdata[7:0];
            end else if (paddr == `ADR_EVT) begin
                s_d.evt = s_q.evt & ~pwdata[2:0];
            end else if (paddr == `ADR_MASK) begin
                s_d.mask = pwdata[2:0];
            end
        end
        if (rd && paddr == `ADR_STAT1) begin
            s_d.armed = 1'b1;
        end
        // mode sequencing
        case (s_q.mode)
            M_OFF: begin
                if (!s_q.off_req && (!s_q.clk_sel[0] || s_q.stable)) begin
                    s_d.mode = sel_mode(s_q.clk_sel);
                    s_d.dco_armed = 1'b0;
                end
            end
            default: begin
                if (s_q.off_req) begin
                    s_d.mode = M_OFF;
                end else if (sel_mode(s_q.clk_sel) != s_q.mode) begin
                    s_d.mode = sel_mode(s_q.clk_sel);
                    if (s_q.mode == M_FBE) begin
                        s_d.dco_armed = 1'b0;
                    end
                end
            end
        endcase
        // loss of clock detection and fallback
        if (any_loss) begin
            s_d.loss_of_clock_flag = 1'b1;
            s_d.evt[0] = 1'b1;
            if (s_q.mode == M_FEE || s_q.mode == M_FEI) begin
                s_d.loss_of_lock_flag = 1'b1;
                s_d.evt[1] = 1'b1;
                s_d.lol_rst = s_q.lock_loss_reset_en;
            end
            if (s_q.clock_loss_reset_en) begin
                s_d.loc_rst = 1'b1;
            end else if (!(s_q.lock_loss_reset_en && (s_q.mode == M_FEE || s_q.mode == M_FEI))) begin
                s_d.clockgen_irq_flag = 1'b1;
            end
            if (s_q.mode == M_FEE && (ref_loss || !reference_ok)) begin
                s_d.mode = M_SCM;
                s_d.clk_sel = 2'h0;
                s_d.dco_armed = 1'b0;
            end else if (s_q.mode == M_FEE) begin
                s_d.mode = M_FBE;
                s_d.clk_sel = 2'h2;
            end else if (s_q.mode == M_FBE && ref_loss) begin
                s_d.mode = M_SCM;
                s_d.clk_sel = 2'h0;
                s_d.dco_armed = 1'b0;
            end
        end
        // cleared on entry only, so the flag can rise again while off
        if (s_d.mode == M_OFF && s_q.mode != M_OFF) begin
            s_d.stable = 1'b0;
            s_d.stab_cnt = 2'h0;
        end
        // read data registered in the setup phase
        s_d.prdata = 32'h0000_0000;
        if (setup && !pwrite) begin
            if (paddr == `ADR_CTRL) begin
                s_d.prdata[6:0] = {s_q.off_req, s_q.lock_loss_reset_en, s_q.clock_loss_reset_en, s_q.loc_dis,
                                   s_q.ref_sel, s_q.clk_sel};
            end else if (paddr == `ADR_STAT1) begin
                s_d.prdata[5:0] = {s_q.clockgen_irq_flag, reference_ok, s_q.loss_of_lock_flag, s_q.loss_of_clock_flag,
                                   mode_code(s_q.mode)};
            end else if (paddr == `ADR_STAT2) begin
                s_d.prdata[0] = s_q.stable;
            end else if (paddr == `ADR_FLTU) begin
                s_d.prdata[3:0] = s_q.filt[11:8];
            end else if (paddr == `ADR_FLTL) begin
                s_d.prdata[7:0] = s_q.filt[7:0];
            end else if (paddr == `ADR_EVT) begin
                s_d.prdata[2:0] = s_q.evt;
            end else if (paddr == `ADR_MASK) begin
                s_d.prdata[2:0] = s_q.mask;
            end
        end
        if (any_loss) begin
            s_d.evt[0] = 1'b1;
        end
        // set after register writes so a clear in the same cycle loses
        if (s_d.stable && !s_q.stable) begin
            s_d.evt[2] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.mode <= M_SCM;
            s_q.filt <= `FLT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign filter_value = s_q.filt;
    assign clock_state = mode_code(s_q.mode);
    assign osc_stable_flag = s_q.stable;
    assign clock_loss_reset = s_q.loc_rst;
    assign lock_loss_reset = s_q.lol_rst;
    assign irq = |(s_q.evt & s_q.mask);

    sequence stat1_read_s;
        rd && paddr == `ADR_STAT1;
    endsequence

    sequence flag_write_s;
        wr && paddr == `ADR_STAT1 && pwdata[`STAT1_IRQ_BIT];
    endsequence

    stable_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.stable |-> s_q.stab_cnt == 2'h2)
        else $error("stable flag set without two good samples");

    off_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_q.mode == M_OFF) |-> !s_q.stable)
        else $error("stable flag set on entering off state");

    off_waits_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.mode == M_OFF && s_q.clk_sel[0] && !s_q.stable |=> s_q.mode == M_OFF)
        else $error("left off state before oscillator stable");

    filter_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `ADR_FLTU && s_q.clk_sel != 2'h0 |=> $stable(s_q.filt))
        else $error("filter written outside self-clocked mode");

    filter_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `ADR_FLTU && s_q.latch_cnt != 2'h0 |=> $stable(s_q.filt))
        else $error("filter written during latch sequence");

    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        stat1_read_s ##1 (!(wr && paddr == `ADR_STAT1))[*2] ##1 flag_write_s ##0 !any_loss
        |=> !s_q.loss_of_clock_flag)
        else $error("loss flag not cleared by read then write");

    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.loss_of_clock_flag && !(wr && paddr == `ADR_STAT1) |=> s_q.loss_of_clock_flag)
        else $error("loss flag dropped without acknowledge");

    fee_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
        any_loss && s_q.mode == M_FEE |=> s_q.mode inside {M_SCM, M_FBE} &&
        clock_state == s_q.clk_sel)
        else $error("engaged external fallback wrong");

    fbe_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
        any_loss && ref_loss && s_q.mode == M_FBE |=> s_q.mode == M_SCM && s_q.clk_sel == 2'h0)
        else $error("bypassed fallback wrong");

    lock_with_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
        any_loss && s_q.mode inside {M_FEE, M_FEI} |=> s_q.loss_of_lock_flag && s_q.loss_of_clock_flag)
        else $error("lock loss not raised with clock loss");

    disable_mon_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.loc_dis |-> !any_loss && !mon.ref_mon && !mon.dco_mon)
        else $error("monitoring while disabled");

    off_refok_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.mode == M_OFF && !(s_q.clk_sel == 2'h2 && s_q.ref_sel) |-> !reference_ok)
        else $error("reference ok high in off state");

    dco_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.mode == M_SCM && !s_q.dco_armed |-> !dco_loss)
        else $error("oscillator watched before stable");

    fee_to_fbe_a: assert property (@(posedge pclk) disable iff (!presetn)
        any_loss && s_q.mode == M_FEE && !ref_loss && reference_ok |=>
        s_q.mode == M_FBE && clock_state == 2'h2)
        else $error("engaged external loss with reference ok not bypassed");

    refok_live_a: assert property (@(posedge pclk) disable iff (!presetn)
        mon.ref_mon && !ref_toggling |-> !reference_ok)
        else $error("reference ok high with reference stalled");
endmodule // clock_gen_loss_monitor
`default_nettype wire

// ===== bench/clock_source_model.sv
`default_nettype none
module clock_source_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ref_run,
    input wire logic osc_run,
    input wire logic err_wobble,
    output logic ref_clk_in,
    output logic loop_osc_clock,
    output logic [11:0] count_error,
    output logic sample_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] div_q;
    // a stopped source holds its last level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 4'h0;
            ref_clk_in <= 1'b0;
            loop_osc_clock <= 1'b0;
            count_error <= 12'h000;
            sample_tick <= 1'b0;
        end else begin
            div_q <= div_q + 4'h1;
            if (ref_run && div_q[0]) begin
                ref_clk_in <= !ref_clk_in;
            end
            if (osc_run) begin
                loop_osc_clock <= !loop_osc_clock;
            end
            sample_tick <= (div_q == 4'hf);
            // wobble moves the error well past the unlock tolerance
            if (div_q == 4'hf) begin
                count_error <= err_wobble ? count_error + 12'h010 : 12'h001;
            end
        end
    end
endmodule // clock_source_model
`default_nettype wire

// ===== bench/clock_gen_loss_monitor_test.sv
`default_nettype none
`include "clkmon_params.svh"
module clock_gen_loss_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic ref_clk_in, loop_osc_clock, sample_tick, xtal_wait, ref_run, osc_run, err_wobble;
    logic [11:0] count_error, filter_value;
    logic [1:0] clock_state;
    logic osc_stable_flag, reference_ok, clock_loss_reset, lock_loss_reset, irq;
    int num_errors, total_checks, cycles, lol_cnt, loc_cnt, n;
    logic [7:0] ctrl_tab [5] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h03};
    logic [1:0] st_tab [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
    logic ok_tab [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    clock_gen_loss_monitor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in),
        .loop_osc_clock(loop_osc_clock), .count_error(count_error),
        .sample_tick(sample_tick), .xtal_wait(xtal_wait), .filter_value(filter_value),
        .clock_state(clock_state), .osc_stable_flag(osc_stable_flag),
        .reference_ok(reference_ok), .clock_loss_reset(clock_loss_reset),
        .lock_loss_reset(lock_loss_reset), .irq(irq));
    clock_source_model i_src (.pclk(pclk), .presetn(presetn), .ref_run(ref_run),
        .osc_run(osc_run), .err_wobble(err_wobble), .ref_clk_in(ref_clk_in),
        .loop_osc_clock(loop_osc_clock), .count_error(count_error),
        .sample_tick(sample_tick));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (lock_loss_reset === 1'b1) begin
            lol_cnt <= lol_cnt + 1;
        end
        if (clock_loss_reset === 1'b1) begin
            loc_cnt <= loc_cnt + 1;
        end
        if (cycles == 30000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // two upper filter writes back to back, the second inside the latch time
    task automatic fltu_twice(input logic [31:0] d0, input logic [31:0] d1);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b1;
        paddr <= `ADR_FLTU;
        pwdata <= d0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        penable <= 1'b0;
        pwdata <= d1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic t_reset();
        apb(1'b0, `ADR_STAT1, 32'h0);
        check(rdata[5:0], 32'h0);
        check(filter_value, `FLT_RESET);
        check(irq, 1'b0);
        apb(1'b0, 8'h20, 32'h0);
        check({rerr, rdata}, {1'b1, 32'h0});
    endtask

    task automatic t_stable();
        repeat (100) @(posedge pclk);
        check(osc_stable_flag, 1'b0);
        err_wobble <= 1'b0;
        repeat (100) @(posedge pclk);
        apb(1'b0, `ADR_STAT2, 32'h0);
        check(rdata[0], 1'b1);
    endtask

    task automatic t_filter();
        apb(1'b1, `ADR_FLTL, 32'h5a);
        apb(1'b1, `ADR_FLTU, 32'h3);
        repeat (4) @(posedge pclk);
        check(filter_value, 12'h35a);
        fltu_twice(32'h1, 32'h6);
        repeat (4) @(posedge pclk);
        check(filter_value, 12'h15a);
        apb(1'b1, `ADR_CTRL, 32'h3);
        apb(1'b1, `ADR_FLTU, 32'h7);
        repeat (4) @(posedge pclk);
        check(filter_value, 12'h15a);
        apb(1'b0, `ADR_FLTU, 32'h0);
        check(rdata[3:0], 4'h1);
        apb(1'b1, `ADR_CTRL, 32'h0);
    endtask

    task automatic t_refok();
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `ADR_CTRL, {24'h0, ctrl_tab[i]});
            repeat (4) @(posedge pclk);
            check(clock_state, st_tab[i]);
            check(reference_ok, ok_tab[i]);
        end
        apb(1'b1, `ADR_CTRL, 32'h0);
    endtask

    task automatic t_loss(input logic [7:0] c, input logic stop_ref, input logic [1:0] st,
        input logic lol);
        n = loc_cnt;
        apb(1'b1, `ADR_CTRL, {24'h0, c});
        repeat (8) @(posedge pclk);
        ref_run <= !stop_ref;
        osc_run <= stop_ref;
        repeat (200) @(posedge pclk);
        check(clock_state, st);
        check(loc_cnt > n, c[4]);
        apb(1'b0, `ADR_CTRL, 32'h0);
        check(rdata[1:0], st);
        ref_run <= 1'b1;
        osc_run <= 1'b1;
        repeat (40) @(posedge pclk);
        check(irq, 1'b0);
        apb(1'b1, `ADR_MASK, 32'h1);
        check(irq, 1'b1);
        apb(1'b1, `ADR_EVT, 32'h7);
        check(irq, 1'b0);
        apb(1'b1, `ADR_MASK, 32'h0);
        apb(1'b0, `ADR_STAT1, 32'h0);
        check(rdata[3:2] & {lol, 1'b1}, {lol, 1'b1});
        apb(1'b1, `ADR_STAT1, 32'h20);
        apb(1'b0, `ADR_STAT1, 32'h0);
        check(rdata[3:2], 2'h0);
        apb(1'b1, `ADR_CTRL, 32'h0);
        repeat (100) @(posedge pclk);
    endtask

    task automatic t_lock_loss_reset_en();
        n = lol_cnt;
        apb(1'b1, `ADR_CTRL, 32'h23);
        repeat (8) @(posedge pclk);
        ref_run <= 1'b0;
        repeat (200) @(posedge pclk);
        check(lol_cnt > n, 1'b1);
        apb(1'b0, `ADR_STAT1, 32'h0);
        check(rdata[5], 1'b0);
        ref_run <= 1'b1;
        apb(1'b1, `ADR_STAT1, 32'h20);
        apb(1'b1, `ADR_EVT, 32'h7);
        apb(1'b1, `ADR_CTRL, 32'h0);
        repeat (100) @(posedge pclk);
    endtask

    task automatic t_disable();
        apb(1'b1, `ADR_CTRL, 32'h0b);
        repeat (8) @(posedge pclk);
        ref_run <= 1'b0;
        repeat (200) @(posedge pclk);
        check(clock_state, 2'h3);
        apb(1'b0, `ADR_STAT1, 32'h0);
        check(rdata[2], 1'b0);
        ref_run <= 1'b1;
        apb(1'b1, `ADR_CTRL, 32'h0);
    endtask

    task automatic t_off();
        apb(1'b1, `ADR_CTRL, 32'h46);
        @(posedge pclk);
        check(osc_stable_flag, 1'b0);
        check(reference_ok, 1'b0);
        xtal_wait <= 1'b1;
        repeat (8) @(posedge pclk);
        check(reference_ok, 1'b1);
        xtal_wait <= 1'b0;
        apb(1'b1, `ADR_CTRL, 32'h01);
        repeat (200) @(posedge pclk);
        check(clock_state, 2'h1);
        apb(1'b1, `ADR_CTRL, 32'h0);
    endtask

    initial begin
        {psel, penable, pwrite, xtal_wait, presetn} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {ref_run, osc_run, err_wobble} = 3'h7;
        {num_errors, total_checks, cycles, lol_cnt, loc_cnt} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_stable();
        t_filter();
        t_refok();
        t_loss(8'h03, 1'b1, 2'h0, 1'b1);
        t_loss(8'h03, 1'b0, 2'h2, 1'b1);
        t_loss(8'h16, 1'b1, 2'h0, 1'b0);
        t_lock_loss_reset_en();
        t_disable();
        t_off();
        results();
    end
endmodule // clock_gen_loss_monitor_test
`default_nettype wire
